// file: dsw_pkg.sv
package dsw_pkg;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam int unsigned STW_WIDTH         = 16;
  localparam int unsigned BIT_CTRL_READY    = 0;
  localparam int unsigned BIT_DRIVE_READY   = 1;
  localparam int unsigned BIT_ENABLE        = 2;
  localparam int unsigned BIT_TRIP          = 3;
  localparam int unsigned BIT_ERR_NO_TRIP   = 4;
  localparam int unsigned BIT_RESERVED      = 5;
  localparam int unsigned BIT_TRIP_LOCK     = 6;
  localparam int unsigned BIT_WARNING       = 7;
  localparam int unsigned BIT_SPEED_AT_REF  = 8;
  localparam int unsigned BIT_BUS_CONTROL   = 9;
  localparam int unsigned BIT_FREQ_IN_LIMIT = 10;
  localparam int unsigned BIT_IN_OPERATION  = 11;
  localparam int unsigned BIT_OVERTEMP_STOP = 12;
  localparam int unsigned BIT_VOLTAGE_EXC   = 13;
  localparam int unsigned BIT_TORQUE_EXC    = 14;
  localparam int unsigned BIT_TIMER_EXC     = 15;

  localparam logic [15:0] STW_RESET         = 16'h0000;

  // ---------------------------------------------------------------
  // value scaling
  // ---------------------------------------------------------------
  localparam int unsigned VAL_WIDTH         = 16;
  localparam logic [15:0] FULL_SCALE        = 16'h4000;
  localparam int unsigned FULL_SCALE_SHIFT  = 14;
  localparam logic [15:0] THERMAL_FULL      = 16'h4000;

  // ---------------------------------------------------------------
  // fault state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DSW_ST_OK     = 2'b00,
    DSW_ST_TRIP   = 2'b01,
    DSW_ST_LOCKED = 2'b11
  } dsw_fault_t;

endpackage : dsw_pkg

// file: dsw_edge.sv
`timescale 1ns/1ps
// rising edge of a same-clock level
module dsw_edge (
  input  wire logic sys_clk_i,
  input  wire logic rst_b_i,
  input  wire logic level_i,
  output logic      rise_o
);

  logic level_ff;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= level_i;
    end
  end

  assign rise_o = level_i & ~level_ff;

endmodule : dsw_edge

// file: dsw_scale.sv
`timescale 1ns/1ps
// maps a signed value against a full-scale figure onto the bus word
module dsw_scale import dsw_pkg::*; #(
  parameter int unsigned W = VAL_WIDTH
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_b_i,
  input  wire logic signed [W-1:0] value_i,
  input  wire logic        [W-1:0] full_i,
  output logic signed      [W-1:0] scaled_o
);

  initial begin
    if (W < 2 || W > 30) $error("dsw_scale: width out of range");
  end

  logic signed [2*W+1:0] prod;
  logic signed [2*W+1:0] quot;
  logic signed [2*W+1:0] lim;

  always_comb begin
    prod = (2*W+2)'(value_i) * (2*W+2)'(signed'({2'b00, FULL_SCALE}));
    if (full_i == '0) begin
      quot = '0;
    end else begin
      quot = prod / signed'((2*W+2)'({1'b0, full_i}));
    end
    // saturate instead of wrapping
    lim = quot;
    if (quot > (2*W+2)'((1 <<< (W-1)) - 1)) begin
      lim = (2*W+2)'((1 <<< (W-1)) - 1);
    end else if (quot < -(2*W+2)'(1 <<< (W-1))) begin
      lim = -(2*W+2)'(1 <<< (W-1));
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scaled_o <= '0;
    end else begin
      scaled_o <= lim[W-1:0];
    end
  end

endmodule : dsw_scale

// file: dsw_status.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Behaviour
// - bit 0 set when control ready, cleared when tripped
// - bit 1 set when ready but coast command still asserted
// - bit 2 zero while coasting, one when enabled to start
// - bit 3 shows tripped state; leaving needs a reset request
// - bit 4 shows an error that does not trip
// - bit 5 reserved, always zero
// - bit 6 shows tripped and locked
// - bit 7 shows any warning present
// - bit 8 set when speed equals reference
// - bit 9 set when bus control accepted, not local or panel stop
// - bit 10 set while frequency strictly inside both limits
// - bit 11 set on start signal or nonzero output frequency
// - bit 12 set during non-tripping over-temperature stop
// - bit 13 set while dc link voltage out of range
// - bit 14 set when current exceeds torque limit
// - bit 15 set when any thermal timer passes full scale
// - whole word zero on option link loss or comm fault
// - reference and output value are 16-bit, 16384 full scale
// - warnings follow their cause, no latching
// - alarm trips and latches until reset after cause gone
// - trip-lock ignores resets until power-on cycle
// - automatic reset clears only non-locked alarms
// - control word reset acts on rising edge only
// ---------------------------------------------------------------
module dsw_status import dsw_pkg::*; #(
  parameter int unsigned N_TIMERS = 2
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_b_i,
  // drive condition
  input  wire logic                        control_ready_i,
  input  wire logic                        coast_cmd_i,
  input  wire logic                        drive_enabled_i,
  input  wire logic                        start_signal_i,
  input  wire logic                        err_no_trip_i,
  input  wire logic                        warning_cause_i,
  input  wire logic                        alarm_cause_i,
  input  wire logic                        alarm_is_lock_i,
  input  wire logic                        local_ctrl_sel_i,
  input  wire logic                        panel_stop_i,
  input  wire logic                        overtemp_stop_i,
  input  wire logic                        dc_volt_low_i,
  input  wire logic                        dc_volt_high_i,
  input  wire logic                        torque_exceeded_i,
  input  wire logic [N_TIMERS*16-1:0]      thermal_timers_i,
  input  wire logic                        option_link_lost_i,
  input  wire logic                        comm_fault_i,
  // frequency and speed
  input  wire logic signed [15:0]          out_freq_i,
  input  wire logic signed [15:0]          freq_low_lim_i,
  input  wire logic signed [15:0]          freq_high_lim_i,
  input  wire logic        [15:0]          freq_full_i,
  input  wire logic signed [15:0]          speed_i,
  input  wire logic signed [15:0]          speed_target_i,
  // reset sources
  input  wire logic                        panel_reset_i,
  input  wire logic                        din_reset_i,
  input  wire logic                        auto_reset_en_i,
  input  wire logic                        auto_reset_req_i,
  // bus side
  input  wire logic [15:0]                 drive_control_word_i,
  input  wire logic signed [15:0]          bus_speed_ref_i,
  output logic [15:0]                      drive_status_word_o,
  output logic signed [15:0]               actual_output_value_o,
  output logic signed [15:0]               speed_ref_o,
  output logic                             tripped_o,
  output logic                             trip_locked_o
);

  initial begin
    if (N_TIMERS < 1) $error("dsw_status: need one timer");
    if (VAL_WIDTH != STW_WIDTH) $error("dsw_status: word width mismatch");
    if (FULL_SCALE_SHIFT >= VAL_WIDTH) $error("dsw_status: full scale too wide");
  end

  localparam int unsigned CW_RESET_BIT = 7;
  localparam int unsigned CW_VALID_BIT = 10;

  // ---------------------------------------------------------------
  // reset request sources
  // ---------------------------------------------------------------
  // same-clock levels from drive logic, so no synchroniser needed
  logic cw_reset_rise;
  logic panel_rise;
  logic din_rise;
  logic cw_reset_lvl;

  assign cw_reset_lvl = drive_control_word_i[CW_RESET_BIT] & drive_control_word_i[CW_VALID_BIT];

  dsw_edge u_cw_edge (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .level_i   (cw_reset_lvl),
    .rise_o    (cw_reset_rise)
  );

  dsw_edge u_panel_edge (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .level_i   (panel_reset_i),
    .rise_o    (panel_rise)
  );

  dsw_edge u_din_edge (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .level_i   (din_reset_i),
    .rise_o    (din_rise)
  );

  // ---------------------------------------------------------------
  // reset decision
  // ---------------------------------------------------------------
  logic manual_reset;
  logic auto_reset;

  assign manual_reset = cw_reset_rise | panel_rise | din_rise;
  assign auto_reset   = auto_reset_en_i & auto_reset_req_i;

  // ---------------------------------------------------------------
  // fault state
  // ---------------------------------------------------------------
  dsw_fault_t fault_ff;
  dsw_fault_t nxt_fault;
  // lock marker: set on entry to lock, blocks manual reset until power-on clears it
  logic       lock_armed_ff;

  always_comb begin
    nxt_fault = fault_ff;
    unique case (fault_ff)
      DSW_ST_OK: begin
        if (alarm_cause_i) begin
          nxt_fault = alarm_is_lock_i ? DSW_ST_LOCKED : DSW_ST_TRIP;
        end
      end
      DSW_ST_TRIP: begin
        // a request during the cause is dropped, not queued
        // latched until reset with cause gone
        if (!alarm_cause_i && (manual_reset || auto_reset)) begin
          nxt_fault = DSW_ST_OK;
        end
      end
      DSW_ST_LOCKED: begin
        // flag set on every entry, so in practice only power-on clears
        // locked until power cycle; auto ignored
        if (!alarm_cause_i && manual_reset && !lock_armed_ff) begin
          nxt_fault = DSW_ST_OK;
        end
      end
      default: nxt_fault = DSW_ST_LOCKED;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_ff <= DSW_ST_OK;
    end else begin
      fault_ff <= nxt_fault;
    end
  end

  // reset is power-on: a lock seen after it stays locked until next power-on
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_armed_ff <= 1'b0;
    end else if (fault_ff == DSW_ST_OK && nxt_fault == DSW_ST_LOCKED) begin
      lock_armed_ff <= 1'b1;
    end else if (nxt_fault == DSW_ST_OK) begin
      lock_armed_ff <= 1'b0;
    end
  end

  logic tripped;
  logic locked;

  assign tripped = (fault_ff != DSW_ST_OK);
  assign locked  = (fault_ff == DSW_ST_LOCKED);

  // ---------------------------------------------------------------
  // value scaling
  // ---------------------------------------------------------------
  // saturates rather than wraps past the 16-bit signed range
  // output value scaled to full scale
  dsw_scale #(
    .W (VAL_WIDTH)
  ) u_out_scale (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .value_i   (out_freq_i),
    .full_i    (freq_full_i),
    .scaled_o  (actual_output_value_o)
  );

  // ---------------------------------------------------------------
  // bus reference
  // ---------------------------------------------------------------
  // reference passed as-is, already full-scale coded
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      speed_ref_o <= '0;
    end else if (drive_control_word_i[CW_VALID_BIT]) begin
      speed_ref_o <= bus_speed_ref_i;
    end
  end

  // ---------------------------------------------------------------
  // condition decode
  // ---------------------------------------------------------------
  logic timer_exc;

  always_comb begin
    timer_exc = 1'b0;
    for (int i = 0; i < N_TIMERS; i++) begin
      if (thermal_timers_i[i*VAL_WIDTH +: VAL_WIDTH] > THERMAL_FULL) begin
        timer_exc = 1'b1;
      end
    end
  end

  logic [15:0] nxt_stw;

  always_comb begin
    nxt_stw = STW_RESET;
    nxt_stw[BIT_CTRL_READY]    = control_ready_i & ~tripped;
    nxt_stw[BIT_DRIVE_READY]   = control_ready_i & ~tripped & coast_cmd_i;
    nxt_stw[BIT_ENABLE]        = drive_enabled_i & ~coast_cmd_i & ~tripped;
    nxt_stw[BIT_TRIP]          = tripped;
    nxt_stw[BIT_ERR_NO_TRIP]   = err_no_trip_i;
    nxt_stw[BIT_RESERVED]      = 1'b0;
    nxt_stw[BIT_TRIP_LOCK]     = locked;
    nxt_stw[BIT_WARNING]       = warning_cause_i;
    nxt_stw[BIT_SPEED_AT_REF]  = (speed_i == speed_target_i);
    nxt_stw[BIT_BUS_CONTROL]   = ~local_ctrl_sel_i & ~panel_stop_i;
    // a value equal to a limit counts as outside
    // strictly within limits
    nxt_stw[BIT_FREQ_IN_LIMIT] = (out_freq_i > freq_low_lim_i) && (out_freq_i < freq_high_lim_i);
    nxt_stw[BIT_IN_OPERATION]  = start_signal_i | (out_freq_i != '0);
    nxt_stw[BIT_OVERTEMP_STOP] = overtemp_stop_i;
    nxt_stw[BIT_VOLTAGE_EXC]   = dc_volt_low_i | dc_volt_high_i;
    nxt_stw[BIT_TORQUE_EXC]    = torque_exceeded_i;
    nxt_stw[BIT_TIMER_EXC]     = timer_exc;
    if (option_link_lost_i || comm_fault_i) begin
      nxt_stw = '0;
    end
  end

  // ---------------------------------------------------------------
  // status word register
  // ---------------------------------------------------------------
  // registered every cycle
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_status_word_o <= STW_RESET;
    end else begin
      drive_status_word_o <= nxt_stw;
    end
  end

  // ---------------------------------------------------------------
  // fault flags
  // ---------------------------------------------------------------
  // flags mirror the next state, one cycle ahead of the word bits
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tripped_o <= 1'b0;
    end else begin
      tripped_o <= (nxt_fault != DSW_ST_OK);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trip_locked_o <= 1'b0;
    end else begin
      trip_locked_o <= (nxt_fault == DSW_ST_LOCKED);
    end
  end

endmodule : dsw_status

// file: dsw_status_monitor.sv
`timescale 1ns/1ps
module dsw_status_monitor (
  input wire logic               sys_clk_i,
  input wire logic               rst_b_i,
  input wire logic               warning_cause_i,
  input wire logic               alarm_cause_i,
  input wire logic               alarm_is_lock_i,
  input wire logic               option_link_lost_i,
  input wire logic               comm_fault_i,
  input wire logic signed [15:0] speed_i,
  input wire logic signed [15:0] speed_target_i,
  input wire logic               panel_reset_i,
  input wire logic               din_reset_i,
  input wire logic               auto_reset_req_i,
  input wire logic [15:0]        drive_control_word_i,
  input wire logic [15:0]        drive_status_word_o,
  input wire logic               tripped_o,
  input wire logic               trip_locked_o
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic link_ok;
  logic any_rst;
  assign link_ok = !option_link_lost_i && !comm_fault_i;
  assign any_rst = panel_reset_i || din_reset_i || auto_reset_req_i || drive_control_word_i[7];
  sequence s_trip_only; tripped_o && !trip_locked_o && link_ok; endsequence
  sequence s_trip_bits; drive_status_word_o[3] && !drive_status_word_o[0]; endsequence
  property p_trip_bits; s_trip_only |=> s_trip_bits; endproperty
  property p_rsv; drive_status_word_o[5] == 1'b0; endproperty
  property p_link; !link_ok |=> drive_status_word_o == 16'h0000; endproperty
  property p_warn; 1'b1 |=> drive_status_word_o[7] == $past(warning_cause_i && link_ok); endproperty
  property p_speed; link_ok && (speed_i != speed_target_i) |=> !drive_status_word_o[8]; endproperty
  property p_trip_enter; alarm_cause_i && !alarm_is_lock_i && !trip_locked_o |=> tripped_o; endproperty
  // two quiet cycles, so a registered edge detector cannot still hold a request
  property p_trip_hold; s_trip_only ##0 (!any_rst && !$past(any_rst)) |=> tripped_o; endproperty
  property p_lock_hold; trip_locked_o |=> trip_locked_o [*2]; endproperty
  property p_lock_bit; trip_locked_o && link_ok |=> drive_status_word_o[6]; endproperty
  a_trip_bits: assert property (p_trip_bits) else $error("trip not shown in status word");
  a_rsv: assert property (p_rsv) else $error("reserved status bit set");
  a_link: assert property (p_link) else $error("status word not cleared on link loss");
  a_warn: assert property (p_warn) else $error("warning bit does not follow cause");
  a_speed: assert property (p_speed) else $error("speed match bit set off reference");
  a_trip_enter: assert property (p_trip_enter) else $error("alarm did not trip");
  a_trip_hold: assert property (p_trip_hold) else $error("trip cleared without request");
  a_lock_hold: assert property (p_lock_hold) else $error("trip lock released early");
  a_lock_bit: assert property (p_lock_bit) else $error("lock bit missing");
endmodule : dsw_status_monitor

bind dsw_status dsw_status_monitor dsw_status_monitor_i (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .warning_cause_i(warning_cause_i),
  .alarm_cause_i(alarm_cause_i), .alarm_is_lock_i(alarm_is_lock_i), .option_link_lost_i(option_link_lost_i),
  .comm_fault_i(comm_fault_i), .speed_i(speed_i), .speed_target_i(speed_target_i),
  .panel_reset_i(panel_reset_i), .din_reset_i(din_reset_i), .auto_reset_req_i(auto_reset_req_i),
  .drive_control_word_i(drive_control_word_i), .drive_status_word_o(drive_status_word_o),
  .tripped_o(tripped_o), .trip_locked_o(trip_locked_o)
);

// file: dsw_bus_master.sv
`timescale 1ns/1ps
module dsw_bus_master (
  input  wire logic               sys_clk_i,
  input  wire logic        [15:0] drive_status_word_i,
  output logic             [15:0] drive_control_word_o,
  output logic signed      [15:0] bus_speed_ref_o
);
  initial begin
    drive_control_word_o = 16'h0000;
    bus_speed_ref_o = 16'sh0000;
  end
  task automatic send(input logic [15:0] cw, input logic signed [15:0] ref_v);
    @(posedge sys_clk_i);
    drive_control_word_o <= cw;
    bus_speed_ref_o <= ref_v;
  endtask : send
  task automatic read_sw(output logic [15:0] sw);
    @(posedge sys_clk_i);
    sw = drive_status_word_i;
  endtask : read_sw
endmodule : dsw_bus_master

// file: tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk_i, rst_b_i, alarm, lock, p_rst, d_rst, a_en, a_req;
  logic [13:0] cond;
  logic signed [15:0] freq, lo, hi, spd, tgt, exp_ref;
  logic [15:0] full, v;
  logic [31:0] tmr, seed;
  wire logic [15:0] cw, sw;
  wire logic signed [15:0] bref, aov, sref;
  wire logic trp, lck;
  int failures, check_count;
  dsw_status dsw_status_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .control_ready_i(cond[0]),
    .coast_cmd_i(cond[1]), .drive_enabled_i(cond[2]), .start_signal_i(cond[3]), .err_no_trip_i(cond[4]),
    .warning_cause_i(cond[5]), .alarm_cause_i(alarm), .alarm_is_lock_i(lock), .local_ctrl_sel_i(cond[6]),
    .panel_stop_i(cond[7]), .overtemp_stop_i(cond[8]), .dc_volt_low_i(cond[9]), .dc_volt_high_i(cond[10]),
    .torque_exceeded_i(cond[11]), .thermal_timers_i(tmr), .option_link_lost_i(cond[12]),
    .comm_fault_i(cond[13]), .out_freq_i(freq), .freq_low_lim_i(lo), .freq_high_lim_i(hi),
    .freq_full_i(full), .speed_i(spd), .speed_target_i(tgt), .panel_reset_i(p_rst), .din_reset_i(d_rst),
    .auto_reset_en_i(a_en), .auto_reset_req_i(a_req), .drive_control_word_i(cw), .bus_speed_ref_i(bref),
    .drive_status_word_o(sw), .actual_output_value_o(aov), .speed_ref_o(sref), .tripped_o(trp),
    .trip_locked_o(lck));
  dsw_bus_master master_i (.sys_clk_i(sys_clk_i),
    .drive_status_word_i(sw), .drive_control_word_o(cw), .bus_speed_ref_o(bref));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected word for a drive that is not tripped
  function automatic logic [15:0] exp_sw();
    logic [15:0] w;
    w = 16'h0000;
    w[0] = cond[0];
    w[1] = cond[0] & cond[1];
    w[2] = cond[2] & !cond[1];
    w[4] = cond[4];
    w[7] = cond[5];
    w[8] = (spd == tgt);
    w[9] = !cond[6] & !cond[7];
    w[10] = (freq > lo) && (freq < hi);
    w[11] = cond[3] || (freq != 16'sh0000);
    w[12] = cond[8];
    w[13] = cond[9] | cond[10];
    w[14] = cond[11];
    w[15] = (tmr[15:0] > 16'h4000) || (tmr[31:16] > 16'h4000);
    if (cond[12] | cond[13]) w = 16'h0000;
    return w;
  endfunction : exp_sw
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic trip(input logic lk, input logic cause);
    @(posedge sys_clk_i);
    alarm <= cause;
    lock <= lk;
    settle();
  endtask : trip
  task automatic pulse(input int s);
    @(posedge sys_clk_i);
    p_rst <= (s == 0);
    d_rst <= (s == 1);
    a_en <= (s == 2);
    a_req <= (s == 2);
    if (s == 3) master_i.send(16'h0480, exp_ref);
    @(posedge sys_clk_i);
    {p_rst, d_rst, a_req} <= 3'h0;
    master_i.send(16'h0400, exp_ref);
    settle();
  endtask : pulse
  task automatic report_and_stop();
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    failures++;
    report_and_stop();
  end
  initial begin
    logic [31:0] r, q;
    seed = 32'h0000E6B4;
    {failures, check_count, exp_ref} = '0;
    {rst_b_i, alarm, lock, p_rst, d_rst, a_en, a_req} = 7'h00;
    cond = 14'h0001;
    {freq, spd, tgt, tmr} = '0;
    lo = 16'sh0100;
    hi = 16'sh3000;
    full = 16'h4000;
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk_i);
      r = xs();
      q = xs();
      cond <= {(r[30:28] == 3'h0), (r[27:25] == 3'h0), r[11:0]};
      freq <= (i % 4 == 0) ? lo : q[15:0];
      spd <= q[31:16];
      tgt <= (i % 3 == 0) ? q[31:16] : r[31:16];
      tmr <= (i % 5 == 0) ? 32'h40004001 : {1'b0, r[14:0], 1'b0, q[14:0]};
      if (r[12]) exp_ref = q[15:0] ^ r[15:0];
      master_i.send(r[12] ? 16'h0400 : 16'h0000, q[15:0] ^ r[15:0]);
      repeat (3) @(posedge sys_clk_i);
      master_i.read_sw(v);
      chk("status", exp_sw(), v);
      chk("output", freq, aov);
      chk("speed_ref", exp_ref, sref);
    end
    @(posedge sys_clk_i);
    cond <= 14'h0001;
    for (int s = 0; s < 4; s++) begin
      trip(1'b0, 1'b1);
      chk("sw_trip", 16'h0008, sw & 16'h0009);
      pulse(s);
      chk("tripped", 16'h0001, {15'h0000, trp});
      trip(1'b0, 1'b0);
      chk("tripped", 16'h0001, {15'h0000, trp});
      pulse(s);
      chk("tripped", 16'h0000, {15'h0000, trp});
      chk("sw_trip", 16'h0000, sw & 16'h0008);
    end
    master_i.send(16'h0480, exp_ref);
    trip(1'b0, 1'b1);
    trip(1'b0, 1'b0);
    chk("tripped", 16'h0001, {15'h0000, trp});
    master_i.send(16'h0400, exp_ref);
    pulse(3);
    chk("tripped", 16'h0000, {15'h0000, trp});
    trip(1'b1, 1'b1);
    chk("locked", 16'h0001, {15'h0000, lck});
    chk("sw_lock", 16'h0040, sw & 16'h0040);
    trip(1'b1, 1'b0);
    pulse(0);
    pulse(2);
    chk("locked", 16'h0001, {15'h0000, lck});
    @(posedge sys_clk_i);
    {rst_b_i, lock, a_en} <= 3'h0;
    settle();
    chk("sw_reset", 16'h0000, sw);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    settle();
    chk("locked", 16'h0000, {15'h0000, lck});
    @(posedge sys_clk_i);
    full <= 16'h2000;
    freq <= 16'sh1000;
    settle();
    chk("output", 16'h2000, aov);
    report_and_stop();
  end
endmodule : tb
